// >>> common/bsiu_pkg.sv
// Constants and types shared by the boundary-scan instruction unit
package bsiu_pkg;

  // ****************************************
  // Register sizes
  // ****************************************
  localparam int IR_W    = 8;
  localparam int BSR_LEN = 121;
  localparam int N_OUT   = 40;

  // ****************************************
  // Instruction codes and the IR capture value
  // ****************************************
  localparam logic [IR_W-1:0] INS_HIGHZ  = 8'h03;
  localparam logic [IR_W-1:0] INS_CLAMP  = 8'h07;
  localparam logic [IR_W-1:0] INS_SAMPLE = 8'h05;
  localparam logic [IR_W-1:0] INS_BYPASS = 8'hff;
  localparam logic [IR_W-1:0] INS_IDCODE = 8'h21;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;

  // ****************************************
  // TAP controller states
  // ****************************************
  typedef enum logic [15:0] {
    TAP_TLR    = 16'h0001,
    TAP_RTI    = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } bsiu_tap_t;

endpackage

// >>> src/bsiu_top.sv
// Boundary-scan instruction unit: TAP, instruction decode, scan paths and output forcing
//
// Notes on behaviour
// [RULE_01] High-Z instruction puts the one-bit bypass register between TDI and TDO.
// [RULE_02] High-Z instruction turns every functional output off.
// [RULE_03] CLAMP makes each output ball drive its held boundary-scan cell value.
// [RULE_04] SAMPLE/PRELOAD in capture-DR records pin states without disturbing memory operation.
// [RULE_05] The pin snapshot is taken on a rising test-clock edge.
// [RULE_06] In shift-DR after capture, the boundary-scan register sits between TDI and TDO.
// [RULE_07] BYPASS in shift-DR routes TDI through the one-bit bypass register to TDO.
// [RULE_08] The controller loads only defined instruction codes; others are reserved.
// [RULE_09] A pin moving during capture harms nothing but its captured value is undefined.
// [RULE_10] Controller should ignore captured memory clock bits when that clock cannot stop.
// [RULE_11] Codes: High-Z 03, CLAMP 07, SAMPLE/PRELOAD 05, BYPASS all ones.
// [RULE_12] Boundary-scan register is 121 bits, MSB at TDI, LSB at TDO.
// [RULE_13] TDI sampled on rising test-clock edges, TDO changes on falling edges.
// [RULE_14] TDO drives only in Shift-IR and Shift-DR, otherwise released.
// [RULE_15] Forcing starts at update-IR and lasts until another instruction or TAP reset.
`timescale 1ns/1ps

module bsiu_top #(
  parameter int BSR_LEN = bsiu_pkg::BSR_LEN,
  parameter int N_OUT   = bsiu_pkg::N_OUT
) (
  input  wire logic               i_sys_clk,   // Memory core clock
  input  wire logic               i_rst,       // Synchronous reset, active high
  input  wire logic               i_tck,       // Test clock
  input  wire logic               i_tms,       // Test mode select
  input  wire logic               i_tdi,       // Serial test input
  input  wire logic [BSR_LEN-1:0] i_pin_state, // Ball levels seen by the scan cells
  input  wire logic [N_OUT-1:0]   i_func_data, // Functional output data
  input  wire logic [N_OUT-1:0]   i_func_oe,   // Functional output enables
  output logic                    o_tdo,       // Serial test output
  output logic                    o_tdo_oe,    // TDO driver enable
  output logic [N_OUT-1:0]        o_ball_data, // Output ball data
  output logic [N_OUT-1:0]        o_ball_oe    // Output ball enables
);

  // ****************************************
  // Test clock domain: reset and pin synchronisers
  // ****************************************
  logic               rst_m_q;
  logic               rst_t_q;
  logic [BSR_LEN-1:0] pin_m_q;
  logic [BSR_LEN-1:0] pin_s_q;

  always_ff @(posedge i_tck) begin
    rst_m_q <= i_rst;
    rst_t_q <= rst_m_q;
    pin_m_q <= i_pin_state;
    pin_s_q <= pin_m_q;
  end

  // ****************************************
  // TAP controller
  // ****************************************
  bsiu_pkg::bsiu_tap_t state_q;
  bsiu_pkg::bsiu_tap_t state_d;

  always_comb begin
    case (state_q)
      bsiu_pkg::TAP_TLR:    state_d = i_tms ? bsiu_pkg::TAP_TLR    : bsiu_pkg::TAP_RTI;
      bsiu_pkg::TAP_RTI:    state_d = i_tms ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_RTI;
      bsiu_pkg::TAP_SEL_DR: state_d = i_tms ? bsiu_pkg::TAP_SEL_IR : bsiu_pkg::TAP_CAP_DR;
      bsiu_pkg::TAP_CAP_DR: state_d = i_tms ? bsiu_pkg::TAP_EX1_DR : bsiu_pkg::TAP_SH_DR;
      bsiu_pkg::TAP_SH_DR:  state_d = i_tms ? bsiu_pkg::TAP_EX1_DR : bsiu_pkg::TAP_SH_DR;
      bsiu_pkg::TAP_EX1_DR: state_d = i_tms ? bsiu_pkg::TAP_UPD_DR : bsiu_pkg::TAP_PAU_DR;
      bsiu_pkg::TAP_PAU_DR: state_d = i_tms ? bsiu_pkg::TAP_EX2_DR : bsiu_pkg::TAP_PAU_DR;
      bsiu_pkg::TAP_EX2_DR: state_d = i_tms ? bsiu_pkg::TAP_UPD_DR : bsiu_pkg::TAP_SH_DR;
      bsiu_pkg::TAP_UPD_DR: state_d = i_tms ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_RTI;
      bsiu_pkg::TAP_SEL_IR: state_d = i_tms ? bsiu_pkg::TAP_TLR    : bsiu_pkg::TAP_CAP_IR;
      bsiu_pkg::TAP_CAP_IR: state_d = i_tms ? bsiu_pkg::TAP_EX1_IR : bsiu_pkg::TAP_SH_IR;
      bsiu_pkg::TAP_SH_IR:  state_d = i_tms ? bsiu_pkg::TAP_EX1_IR : bsiu_pkg::TAP_SH_IR;
      bsiu_pkg::TAP_EX1_IR: state_d = i_tms ? bsiu_pkg::TAP_UPD_IR : bsiu_pkg::TAP_PAU_IR;
      bsiu_pkg::TAP_PAU_IR: state_d = i_tms ? bsiu_pkg::TAP_EX2_IR : bsiu_pkg::TAP_PAU_IR;
      bsiu_pkg::TAP_EX2_IR: state_d = i_tms ? bsiu_pkg::TAP_UPD_IR : bsiu_pkg::TAP_SH_IR;
      bsiu_pkg::TAP_UPD_IR: state_d = i_tms ? bsiu_pkg::TAP_SEL_DR : bsiu_pkg::TAP_RTI;
      default:              state_d = bsiu_pkg::TAP_TLR;
    endcase
  end

  always_ff @(posedge i_tck) begin
    if (rst_t_q) begin
      state_q <= bsiu_pkg::TAP_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Instruction, bypass and boundary-scan registers
  // ****************************************
  logic [bsiu_pkg::IR_W-1:0] ir_sh_q;
  logic [bsiu_pkg::IR_W-1:0] ir_sh_d;
  logic [bsiu_pkg::IR_W-1:0] ir_q;
  logic [bsiu_pkg::IR_W-1:0] ir_d;
  logic                      byp_q;
  logic                      byp_d;
  logic [BSR_LEN-1:0]        bsr_q;
  logic [BSR_LEN-1:0]        bsr_d;
  logic [BSR_LEN-1:0]        upd_q;
  logic [BSR_LEN-1:0]        upd_d;
  logic                      hiz_q;
  logic                      hiz_d;
  logic                      clamp_q;
  logic                      clamp_d;
  logic                      sel_bsr;

  // Reserved codes and the reset code fall back to the bypass path
  assign sel_bsr = (ir_q == bsiu_pkg::INS_SAMPLE); // RULE_11

  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d    = ir_q;
    byp_d   = byp_q;
    bsr_d   = bsr_q;
    upd_d   = upd_q;
    case (state_q)
      bsiu_pkg::TAP_TLR:    ir_d    = bsiu_pkg::INS_IDCODE; // RULE_15
      bsiu_pkg::TAP_CAP_IR: ir_sh_d = bsiu_pkg::IR_CAPTURE;
      bsiu_pkg::TAP_SH_IR:  ir_sh_d = {i_tdi, ir_sh_q[bsiu_pkg::IR_W-1:1]}; // RULE_13
      bsiu_pkg::TAP_UPD_IR: ir_d    = ir_sh_q; // RULE_15
      bsiu_pkg::TAP_CAP_DR: begin
        byp_d = 1'b0;
        // Snapshot only; functional paths never see the scan cells here
        if (sel_bsr) begin
          bsr_d = pin_s_q; // RULE_04 RULE_05 RULE_09
        end
      end
      bsiu_pkg::TAP_SH_DR: begin
        if (sel_bsr) begin
          bsr_d = {i_tdi, bsr_q[BSR_LEN-1:1]}; // RULE_06 RULE_12
        end else begin
          byp_d = i_tdi; // RULE_01 RULE_07
        end
      end
      bsiu_pkg::TAP_UPD_DR: begin
        if (sel_bsr) begin
          upd_d = bsr_q;
        end
      end
      default: begin
      end
    endcase
    hiz_d   = (ir_d == bsiu_pkg::INS_HIGHZ); // RULE_02 RULE_15
    clamp_d = (ir_d == bsiu_pkg::INS_CLAMP); // RULE_03 RULE_15
  end

  always_ff @(posedge i_tck) begin
    if (rst_t_q) begin
      ir_sh_q <= bsiu_pkg::IR_CAPTURE;
      ir_q    <= bsiu_pkg::INS_IDCODE;
      byp_q   <= 1'b0;
      bsr_q   <= '0;
      upd_q   <= '0;
      hiz_q   <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      ir_sh_q <= ir_sh_d;
      ir_q    <= ir_d;
      byp_q   <= byp_d;
      bsr_q   <= bsr_d;
      upd_q   <= upd_d;
      hiz_q   <= hiz_d;
      clamp_q <= clamp_d;
    end
  end

  // ****************************************
  // TDO on the falling edge
  // ****************************************
  logic tdo_d;
  logic tdo_oe_d;

  always_comb begin
    if (state_q == bsiu_pkg::TAP_SH_IR) begin
      tdo_d = ir_sh_q[0];
    end else if (sel_bsr) begin
      tdo_d = bsr_q[0]; // RULE_06 RULE_12
    end else begin
      tdo_d = byp_q; // RULE_01 RULE_07
    end
    tdo_oe_d = (state_q == bsiu_pkg::TAP_SH_IR) || (state_q == bsiu_pkg::TAP_SH_DR); // RULE_14
  end

  always_ff @(negedge i_tck) begin
    if (rst_t_q) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo    <= tdo_d; // RULE_13
      o_tdo_oe <= tdo_oe_d;
    end
  end

  // ****************************************
  // System domain: output forcing
  // ****************************************
  logic             hiz_m_q;
  logic             hiz_s_q;
  logic             clamp_m_q;
  logic             clamp_s_q;
  logic [N_OUT-1:0] word_q;
  logic [N_OUT-1:0] word_d;
  logic [N_OUT-1:0] bdata_d;
  logic [N_OUT-1:0] boe_d;

  always_ff @(posedge i_sys_clk) begin
    hiz_m_q   <= hiz_q;
    hiz_s_q   <= hiz_m_q;
    clamp_m_q <= clamp_q;
    clamp_s_q <= clamp_m_q;
  end

  // Update cells are quiet whenever CLAMP is loaded, since the bypass path is
  // selected; tracking them only while clamp is off keeps the word stable
  always_comb begin
    word_d = clamp_s_q ? word_q : upd_q[N_OUT-1:0];
    if (hiz_s_q) begin
      bdata_d = i_func_data;
      boe_d   = '0; // RULE_02
    end else if (clamp_s_q) begin
      bdata_d = word_q; // RULE_03
      boe_d   = '1;
    end else begin
      bdata_d = i_func_data;
      boe_d   = i_func_oe;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      word_q      <= '0;
      o_ball_data <= '0;
      o_ball_oe   <= '0;
    end else begin
      word_q      <= word_d;
      o_ball_data <= bdata_d;
      o_ball_oe   <= boe_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_tms_high5;
    i_tms [*5];
  endsequence

  sequence s_highz_shift;
    (state_q == bsiu_pkg::TAP_SH_DR) && (ir_q == bsiu_pkg::INS_HIGHZ);
  endsequence

  a_tap_reset: assert property (@(posedge i_tck) disable iff (rst_t_q) // RULE_15
    s_tms_high5 ##1 i_tms |=> (ir_q == bsiu_pkg::INS_IDCODE) && !hiz_q && !clamp_q)
    else $error("TAP reset did not restore the reset instruction");

  a_hiz_bypass: assert property (@(posedge i_tck) disable iff (rst_t_q) // RULE_01
    s_highz_shift |=> byp_q == $past(i_tdi))
    else $error("High-Z does not shift through bypass");

  a_bypass_path: assert property (@(posedge i_tck) disable iff (rst_t_q) // RULE_07
    (state_q == bsiu_pkg::TAP_SH_DR) && (ir_q == bsiu_pkg::INS_BYPASS)
    ##1 (state_q == bsiu_pkg::TAP_SH_DR) |-> ##0 !sel_bsr && (o_tdo == byp_q))
    else $error("Bypass path not between TDI and TDO");

  a_capture_snap: assert property (@(posedge i_tck) disable iff (rst_t_q) // RULE_05
    (state_q == bsiu_pkg::TAP_CAP_DR) && sel_bsr |=> bsr_q == $past(pin_s_q))
    else $error("Snapshot not taken at capture");

  a_bsr_shift: assert property (@(posedge i_tck) disable iff (rst_t_q) // RULE_06
    (state_q == bsiu_pkg::TAP_SH_DR) && sel_bsr
    |=> (bsr_q[BSR_LEN-1] == $past(i_tdi)) && (bsr_q[BSR_LEN-2:0] == $past(bsr_q[BSR_LEN-1:1])))
    else $error("Boundary register shift wrong");

  // Sampled at the rising edge: the enable was set at the falling edge from the same state
  a_tdo_enable: assert property (@(posedge i_tck) disable iff (rst_t_q) // RULE_14
    ((state_q == bsiu_pkg::TAP_SH_IR) || (state_q == bsiu_pkg::TAP_SH_DR)) |-> o_tdo_oe)
    else $error("TDO not enabled in a shift state");

  a_tdo_release: assert property (@(posedge i_tck) disable iff (rst_t_q) // RULE_14
    !((state_q == bsiu_pkg::TAP_SH_IR) || (state_q == bsiu_pkg::TAP_SH_DR)) |-> !o_tdo_oe)
    else $error("TDO enable outside shift states");

  a_hiz_outputs: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_02
    hiz_s_q |=> o_ball_oe == '0)
    else $error("Outputs driven under High-Z");

  a_clamp_drive: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_03
    clamp_s_q && !hiz_s_q |=> (o_ball_oe == '1) && (o_ball_data == $past(word_q)))
    else $error("Clamp does not drive held cell values");

endmodule

// >>> tb/bsiu_jtag_model.sv
// Test controller model driving the serial test link of the instruction unit
`timescale 1ns/1ps

module bsiu_jtag_model (
  output logic      o_tck,    // Test clock, low between frames
  output logic      o_tms,    // Test mode select
  output logic      o_tdi,    // Serial test data out
  input  wire logic i_tdo,    // Serial test data in
  input  wire logic i_tdo_oe  // Device drives TDO
);
  logic tdo_seen;

  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  // ****************************************
  // One 80 ns test-clock cycle
  // ****************************************
  task automatic step(input logic tms, input logic tdi);
    o_tms = tms;
    o_tdi = tdi;
    #32;
    tdo_seen = i_tdo_oe ? i_tdo : 1'bz;
    #1 o_tck = 1'b1;
    #40 o_tck = 1'b0;
    #7;
  endtask

  task automatic tap_reset();
    for (int i = 0; i < 6; i++) begin
      step(1'b1, 1'b0);
    end
    step(1'b0, 1'b0);
  endtask

  // Only the defined codes are ever handed in
  task automatic load_ir(input logic [7:0] code, output logic [7:0] cap);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      step(i == 7, code[i]);
      cap[i] = tdo_seen;
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask

  // The caller compares every captured cell, clock cells included
  task automatic scan_dr(input int n, input logic [120:0] din, output logic [120:0] dout);
    dout = '0;
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = tdo_seen;
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule

// >>> tb/boundary_scan_instruction_unit_tb_top.sv
// Self-checking bench for the boundary-scan instruction unit
`timescale 1ns/1ps

module boundary_scan_instruction_unit_tb_top;
  localparam int BL = bsiu_pkg::BSR_LEN;
  localparam int NO = bsiu_pkg::N_OUT;
  localparam logic [BL-1:0] PAT_A = {11{11'h5a3}};
  localparam logic [BL-1:0] PAT_B = {11{11'h2c6}};
  logic          i_sys_clk;
  logic          i_rst;
  logic          tck;
  logic          tms;
  logic          tdi;
  logic          tdo;
  logic          tdo_oe;
  logic [BL-1:0] pin_state;
  logic [NO-1:0] func_data;
  logic [NO-1:0] func_oe;
  logic [NO-1:0] ball_data;
  logic [NO-1:0] ball_oe;
  logic [7:0]    ir_cap;
  logic [BL-1:0] dout;
  int            n_errors;
  int            checked;
  int            cycles;

  bsiu_top i_bsiu_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_pin_state(pin_state), .i_func_data(func_data), .i_func_oe(func_oe), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .o_ball_data(ball_data), .o_ball_oe(ball_oe));

  bsiu_jtag_model i_bsiu_jtag_model (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(tdo_oe));

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [BL-1:0] got, input logic [BL-1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_bypass();
    i_bsiu_jtag_model.load_ir(8'hff, ir_cap);
    chk(ir_cap, 8'h01, "captured instruction");
    i_bsiu_jtag_model.scan_dr(8, 121'h0a5, dout);
    chk(dout[7:0], 8'h4a, "bypass path");
    chk(tdo_oe, 1'b0, "TDO enable in idle");
  endtask

  task automatic t_highz();
    i_bsiu_jtag_model.load_ir(8'h03, ir_cap);
    repeat (8) @(posedge i_sys_clk);
    chk(ball_oe, '0, "outputs off");
    i_bsiu_jtag_model.scan_dr(8, 121'h0c3, dout);
    chk(dout[7:0], 8'h86, "high-z bypass path");
    chk(ball_oe, '0, "outputs stay off");
    i_bsiu_jtag_model.load_ir(8'hff, ir_cap);
    repeat (8) @(posedge i_sys_clk);
    chk(ball_oe, func_oe, "enables back");
    chk(ball_data, func_data, "data back");
  endtask

  task automatic t_sample();
    @(posedge i_sys_clk) pin_state <= PAT_A;
    i_bsiu_jtag_model.load_ir(8'h05, ir_cap);
    i_bsiu_jtag_model.scan_dr(BL, PAT_B, dout);
    chk(dout, PAT_A, "snapshot shifted out");
    chk(ball_oe, func_oe, "memory undisturbed");
  endtask

  task automatic t_clamp();
    i_bsiu_jtag_model.load_ir(8'h07, ir_cap);
    repeat (8) @(posedge i_sys_clk);
    chk(ball_data, PAT_B[NO-1:0], "clamp word");
    chk(ball_oe, {NO{1'b1}}, "clamp enables");
    @(posedge i_sys_clk) func_data <= ~func_data;
    repeat (6) @(posedge i_sys_clk);
    chk(ball_data, PAT_B[NO-1:0], "clamp holds");
    i_bsiu_jtag_model.tap_reset();
    repeat (8) @(posedge i_sys_clk);
    chk(ball_data, func_data, "reset ends clamp");
  endtask

  initial begin
    i_rst = 1'b1;
    pin_state = '0;
    func_data = 40'h123456789a;
    func_oe = 40'hf0f0a55aff;
    repeat (2) @(posedge i_sys_clk);
    // Test-clock side only sees reset while its clock runs
    i_bsiu_jtag_model.tap_reset();
    @(posedge i_sys_clk) i_rst <= 1'b0;
    i_bsiu_jtag_model.tap_reset();
    chk(tdo_oe, 1'b0, "TDO enable after reset");
    t_bypass();
    t_highz();
    t_sample();
    t_clamp();
    close_out();
  end
endmodule
